// File: verilog/parallel_flash_bus_interface.v
`default_nettype none
`include "flash_bus_map.vh"

// Function
// - Reset pin low: disable operations, ignore inputs, tri-state data outputs.
// - Reset pin low aborts any running erase or program.
// - Chip select high: standby, inputs ignored, outputs tri-stated regardless of OE.
// - Standby leaves a running erase or program untouched.
// - OE high with CE low: data tri-state; wait driven on mux, tri-state otherwise.
// - Read mode bit 1 with CE and OE low starts an asynchronous read.
// - Page reads give further buffer words when only the low four bits change.
// - Read mode bit 0 with CE, OE, address valid low starts a burst.
// - First burst word appears after the configured latency in clocks.
// - Array bursts step to the next address each clock until length reached.
// - Non-array bursts repeat the same word each clock until length reached.
// - Slower parts latch on address-valid rise or first clock rise, whichever first.
// - Faster parts latch on the last clock edge while address valid low.
// - Burst starts at the addressed word; wrap bit selects wrap or continue.
// - No stall for sense-group aligned starts or bursts not crossing a wordline.
// - Unaligned wordline crossing stalls once, latency minus one clocks, wait asserted.
// - CE and WE low, OE high is a write; sampled at first CE or WE rise.
// - Mux variant: address at first ADV or CE rise, data at WE or CE rise.
// - Wait polarity is configurable; asserted means data invalid.
module parallel_flash_bus_interface (
  input  wire                  i_core_clk,       // Core clock, 100 MHz
  input  wire                  i_reset,          // Synchronous reset, active high
  input  wire                  i_reset_pin_n,    // Device reset pin, low true
  input  wire                  i_chip_sel_n,     // Chip select pin, low true
  input  wire                  i_out_en_n,       // Output enable pin, low true
  input  wire                  i_wr_en_n,        // Write enable pin, low true
  input  wire                  i_address_valid_low, // Address valid pin, low true
  input  wire                  i_burst_clk,      // Burst clock pin from host
  input  wire [`FB_ADDR_W-1:0] i_addr,           // Address pins
  input  wire [`FB_DATA_W-1:0] i_dq,             // Data pins, input side
  output reg  [`FB_DATA_W-1:0] o_dq,             // Data pins, output side
  output reg                   o_dq_oe,          // Data pins driven while high
  output reg                   o_wait,           // Wait pin level
  output reg                   o_wait_oe,        // Wait pin driven while high
  input  wire                  i_read_mode_select_bit, // 1 async, 0 burst
  input  wire                  i_burst_wrap_bit, // 1 continue, 0 wrap in group
  input  wire [1:0]            i_burst_len,      // 8, 16 or continuous words
  input  wire [3:0]            i_latency,        // Initial latency in clocks
  input  wire                  i_wait_polarity,  // 1 wait active high
  input  wire                  i_shared_addr_data_variant, // Mux variant select
  input  wire                  i_fast_part,      // 1 selects last-edge latching
  input  wire                  i_array_mode,     // Partition reads array data
  input  wire                  i_op_busy,        // Erase or program running
  input  wire [`FB_DATA_W-1:0] i_mem_rd_data,    // Word at o_mem_addr, same clock
  output reg  [`FB_ADDR_W-1:0] o_mem_addr,       // Read address to the array
  output reg                   o_wr_strobe,      // One-cycle bus write pulse
  output reg  [`FB_ADDR_W-1:0] o_wr_addr,        // Bus write address
  output reg  [`FB_DATA_W-1:0] o_wr_data,        // Bus write data
  output reg                   o_abort           // Abort running erase or program
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_ASYNC = 3'h1;
  localparam [2:0] ST_ADDR  = 3'h2;
  localparam [2:0] ST_LAT   = 3'h3;
  localparam [2:0] ST_BURST = 3'h4;
  localparam [2:0] ST_STALL = 3'h5;
  localparam [2:0] ST_WRITE = 3'h6;
  localparam [2:0] ST_END   = 3'h7;

  localparam CTL_W = 6;
  localparam SYN_W = CTL_W + `FB_ADDR_W + `FB_DATA_W;

  wire [SYN_W-1:0] sync_bus;
  wire [SYN_W-1:0] sync_idle;

  // Pins idle deselected, burst clock low, so reset never looks like a cycle
  assign sync_idle = {5'h1F, 1'h0, `FB_ADDR_RST, `FB_DQ_RST};

  pin_sync #(
    .W (SYN_W)
  ) u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_async    ({i_reset_pin_n, i_chip_sel_n, i_out_en_n, i_wr_en_n,
                  i_address_valid_low, i_burst_clk, i_addr, i_dq}),
    .i_rst_val  (sync_idle),
    .o_sync     (sync_bus)
  );

  wire                  rst_n_s = sync_bus[SYN_W-1];
  wire                  ce_n_s  = sync_bus[SYN_W-2];
  wire                  oe_n_s  = sync_bus[SYN_W-3];
  wire                  we_n_s  = sync_bus[SYN_W-4];
  wire                  adv_n_s = sync_bus[SYN_W-5];
  wire                  lclk_s  = sync_bus[SYN_W-6];
  wire [`FB_ADDR_W-1:0] addr_s  = sync_bus[`FB_ADDR_W+`FB_DATA_W-1:`FB_DATA_W];
  wire [`FB_DATA_W-1:0] dq_s    = sync_bus[`FB_DATA_W-1:0];

  reg                   ce_n_p_q;
  reg                   we_n_p_q;
  reg                   adv_n_p_q;
  reg                   lclk_p_q;

  wire clk_rise = lclk_s & ~lclk_p_q;
  wire adv_rise = adv_n_s & ~adv_n_p_q;
  wire ce_rise  = ce_n_s & ~ce_n_p_q;
  wire we_rise  = we_n_s & ~we_n_p_q;

  // Mux variant carries the low address on the data pins
  wire [`FB_ADDR_W-1:0] pin_addr = i_shared_addr_data_variant ?
                                   {addr_s[`FB_ADDR_W-1:`FB_MUX_LO_W], dq_s} : addr_s;

  reg  [2:0]            state_q;
  reg  [`FB_ADDR_W-1:0] wr_addr_hold_q;
  reg                   wa_latched_q;
  reg  [3:0]            cnt_q;
  reg  [4:0]            words_q;
  reg                   start_unal_q;
  reg                   stalled_q;
  reg                   wait_act_q;

  wire [`FB_ADDR_W-1:0] next_addr;
  wire                  next_wl_cross;

  burst_addr_gen u_burst_addr_gen (
    .i_addr     (o_mem_addr),
    .i_len      (i_burst_len),
    .i_wrap_bit (i_burst_wrap_bit),
    .i_array    (i_array_mode),
    .o_next     (next_addr),
    .o_wl_cross (next_wl_cross)
  );

  wire [3:0] lat_m1   = (i_latency == 4'h0) ? 4'h0 : i_latency - 4'h1;
  wire [3:0] cnt_inc  = cnt_q + 4'h1;
  wire       len_done = (i_burst_len == `FB_LEN_8  && words_q == `FB_LEN_8_WORDS) ||
                        (i_burst_len == `FB_LEN_16 && words_q == `FB_LEN_16_WORDS);
  // Stall only once, only for an unaligned start, only if latency leaves room
  wire       need_stall = next_wl_cross && start_unal_q && !stalled_q &&
                          (lat_m1 != 4'h0);
  wire       read_req  = !ce_n_s && !oe_n_s && we_n_s;
  wire       write_req = !ce_n_s && !we_n_s && oe_n_s;

  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      ce_n_p_q  <= 1'h1;
      we_n_p_q  <= 1'h1;
      adv_n_p_q <= 1'h1;
      lclk_p_q  <= 1'h0;
    end
    else
    begin
      ce_n_p_q  <= ce_n_s;
      we_n_p_q  <= we_n_s;
      adv_n_p_q <= adv_n_s;
      lclk_p_q  <= lclk_s;
    end
  end

  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state_q        <= ST_IDLE;
      wr_addr_hold_q <= `FB_ADDR_RST;
      wa_latched_q   <= 1'h0;
      cnt_q          <= `FB_CNT_RST;
      words_q        <= `FB_WORDS_RST;
      start_unal_q   <= 1'h0;
      stalled_q      <= 1'h0;
      wait_act_q     <= 1'h0;
      o_dq           <= `FB_DQ_RST;
      o_mem_addr     <= `FB_ADDR_RST;
      o_wr_strobe    <= 1'h0;
      o_wr_addr      <= `FB_ADDR_RST;
      o_wr_data      <= `FB_DQ_RST;
      o_abort        <= 1'h0;
    end
    else
    begin
      o_wr_strobe <= 1'h0;
      // Abort tracks the pin, never standby
      o_abort     <= !rst_n_s && i_op_busy;
      if (!rst_n_s)
      begin
        state_q    <= ST_IDLE;
        wait_act_q <= 1'h0;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            wait_act_q   <= 1'h0;
            wa_latched_q <= 1'h0;
            stalled_q    <= 1'h0;
            if (write_req)
              state_q <= ST_WRITE;
            else if (read_req && i_read_mode_select_bit == `FB_RMODE_ASYNC)
              state_q <= ST_ASYNC;
            else if (read_req && !adv_n_s)
            begin
              state_q    <= ST_ADDR;
              wait_act_q <= 1'h1;
            end
          end
          ST_ASYNC:
          begin
            // Live address while ADV low, held after its rise; a page
            // hit simply re-reads so low-bit toggles give the next word
            if (!adv_n_s)
              o_mem_addr <= pin_addr;
            o_dq <= i_mem_rd_data;
            if (!read_req)
              state_q <= ST_IDLE;
          end
          ST_ADDR:
          begin
            if (!read_req)
              state_q <= ST_IDLE;
            else if (i_fast_part)
            begin
              if (clk_rise && !adv_n_s)
              begin
                o_mem_addr   <= pin_addr;
                start_unal_q <= |pin_addr[`FB_SENSE_BITS-1:0];
                cnt_q        <= 4'h1;
              end
              else if (adv_rise)
                state_q <= ST_LAT;
            end
            else if (clk_rise || adv_rise)
            begin
              o_mem_addr   <= pin_addr;
              start_unal_q <= |pin_addr[`FB_SENSE_BITS-1:0];
              cnt_q        <= clk_rise ? 4'h1 : 4'h0;
              state_q      <= ST_LAT;
            end
          end
          ST_LAT:
          begin
            if (!read_req)
              state_q <= ST_IDLE;
            else if (clk_rise)
            begin
              cnt_q <= cnt_inc;
              if (cnt_inc >= i_latency)
              begin
                // First word is the addressed one within its group
                o_dq       <= i_mem_rd_data;
                wait_act_q <= 1'h0;
                words_q    <= 5'h01;
                o_mem_addr <= next_addr;
                state_q    <= need_stall ? ST_STALL : ST_BURST;
                cnt_q      <= 4'h0;
              end
            end
          end
          ST_BURST:
          begin
            if (!read_req)
              state_q <= ST_IDLE;
            else if (clk_rise)
            begin
              if (len_done)
                state_q <= ST_END;
              else
              begin
                o_dq       <= i_mem_rd_data;
                words_q    <= words_q + 5'h01;
                o_mem_addr <= next_addr;
                // Aligned or non-crossing bursts never stall
                if (need_stall)
                begin
                  state_q <= ST_STALL;
                  cnt_q   <= 4'h0;
                end
              end
            end
          end
          ST_STALL:
          begin
            if (!read_req)
              state_q <= ST_IDLE;
            else if (clk_rise)
            begin
              stalled_q <= 1'h1;
              if (cnt_q >= lat_m1)
              begin
                o_dq       <= i_mem_rd_data;
                wait_act_q <= 1'h0;
                words_q    <= words_q + 5'h01;
                o_mem_addr <= next_addr;
                state_q    <= ST_BURST;
              end
              else
              begin
                wait_act_q <= 1'h1;
                cnt_q      <= cnt_inc;
              end
            end
          end
          ST_END:
          begin
            // Last word stays on the pins until the host ends the cycle
            if (!read_req)
              state_q <= ST_IDLE;
          end
          ST_WRITE:
          begin
            // Mux address is caught while ADV is low and frozen at the
            // first ADV or CE rise
            if (i_shared_addr_data_variant && !wa_latched_q)
            begin
              if (!adv_n_s)
                wr_addr_hold_q <= pin_addr;
              if (adv_rise || ce_rise)
                wa_latched_q <= 1'h1;
            end
            if (we_rise || ce_rise)
            begin
              o_wr_strobe <= 1'h1;
              o_wr_data   <= dq_s;
              o_wr_addr   <= i_shared_addr_data_variant ?
                             (wa_latched_q ? wr_addr_hold_q : pin_addr) : addr_s;
              state_q     <= ST_IDLE;
            end
            else if (!oe_n_s)
              state_q <= ST_IDLE;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  wire reading = (state_q == ST_ASYNC) || (state_q == ST_LAT) ||
                 (state_q == ST_BURST) || (state_q == ST_STALL) ||
                 (state_q == ST_END)   || (state_q == ST_ADDR);

  // Pad enables and wait level
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      o_dq_oe   <= 1'h0;
      o_wait_oe <= 1'h0;
      o_wait    <= 1'h0;
    end
    else
    begin
      // Asserted wait means data not valid, polarity chosen by software
      o_wait <= i_wait_polarity ? wait_act_q : ~wait_act_q;
      if (!rst_n_s || ce_n_s)
      begin
        o_dq_oe   <= 1'h0;
        o_wait_oe <= 1'h0;
      end
      else if (oe_n_s)
      begin
        o_dq_oe   <= 1'h0;
        o_wait_oe <= i_shared_addr_data_variant;
        o_wait    <= ~i_wait_polarity;
      end
      else
      begin
        o_dq_oe   <= reading;
        o_wait_oe <= reading;
      end
    end
  end

endmodule // parallel_flash_bus_interface

`default_nettype wire

// File: inc/flash_bus_map.vh
`ifndef FLASH_BUS_MAP_VH
`define FLASH_BUS_MAP_VH

// Pin widths
`define FB_ADDR_W        24
`define FB_DATA_W        16
// Lower address lines shared with data pins on the multiplexed variant
`define FB_MUX_LO_W      16

// Array geometry in address bits
`define FB_PAGE_BITS     4
`define FB_SENSE_BITS    4
`define FB_WL_BITS       8

// Burst length codes
`define FB_LEN_8         2'h0
`define FB_LEN_16        2'h1
`define FB_LEN_CONT      2'h2
`define FB_LEN_8_WORDS   5'h08
`define FB_LEN_16_WORDS  5'h10

// Configuration bit values
`define FB_RMODE_ASYNC   1'h1
`define FB_RMODE_SYNC    1'h0
`define FB_WRAP_OFF      1'h1

// Reset values
`define FB_DQ_RST        16'h0000
`define FB_ADDR_RST      24'h000000
`define FB_CNT_RST       4'h0
`define FB_WORDS_RST     5'h00

`endif

// File: verilog/pin_sync.v
`default_nettype none

module pin_sync #(
  parameter W = 1
) (
  input  wire         i_core_clk,  // Core clock
  input  wire         i_reset,     // Synchronous reset, active high
  input  wire [W-1:0] i_async,     // Pins from outside the clock domain
  input  wire [W-1:0] i_rst_val,   // Constant idle level per bit
  output reg  [W-1:0] o_sync       // Two-stage synchronised copy
);

  reg [W-1:0] meta_q;

  // First stage is read only by the second stage
  always @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      meta_q <= i_rst_val;
      o_sync <= i_rst_val;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // pin_sync

`default_nettype wire

// File: verilog/burst_addr_gen.v
`default_nettype none
`include "flash_bus_map.vh"

module burst_addr_gen (
  input  wire [`FB_ADDR_W-1:0] i_addr,      // Address of the current word
  input  wire [1:0]            i_len,       // Burst length code
  input  wire                  i_wrap_bit,  // burst_wrap_bit
  input  wire                  i_array,     // Array data, else repeat word
  output reg  [`FB_ADDR_W-1:0] o_next,      // Address of the next word
  output reg                   o_wl_cross   // Next word starts a wordline
);

  function [`FB_ADDR_W-1:0] group_mask;
    input [1:0] len;
    begin
      case (len)
        `FB_LEN_8:  group_mask = 24'h000007;
        `FB_LEN_16: group_mask = 24'h00000F;
        default:    group_mask = 24'hFFFFFF;
      endcase
    end
  endfunction

  reg [`FB_ADDR_W-1:0] inc;
  reg [`FB_ADDR_W-1:0] mask;

  always @*
  begin
    inc  = i_addr + 24'h000001;
    mask = group_mask(i_len);
    if (!i_array)
      o_next = i_addr;
    else if (i_wrap_bit != `FB_WRAP_OFF)
      o_next = (i_addr & ~mask) | (inc & mask);
    else
      o_next = inc;
    o_wl_cross = i_array && (o_next[`FB_WL_BITS-1:0] == 8'h00) && (o_next == inc);
  end

endmodule // burst_addr_gen

`default_nettype wire

// File: test/parallel_flash_bus_interface_asserts.sv
`default_nettype none
module parallel_flash_bus_interface_asserts (
  input wire logic       i_core_clk,             // Clock
  input wire logic       i_reset,                // Core reset
  input wire logic       i_reset_pin_n,          // Pin
  input wire logic       i_chip_sel_n,           // Pin
  input wire logic       i_out_en_n,             // Pin
  input wire logic       i_wr_en_n,              // Pin
  input wire logic       i_address_valid_low,    // Pin
  input wire logic       i_burst_clk,            // Pin
  input wire logic       i_read_mode_select_bit, // Config
  input wire logic [3:0] i_latency,              // Config
  input wire logic       i_wait_polarity,        // Config
  input wire logic       i_shared_addr_data_variant, // Config
  input wire logic       i_op_busy,              // Array busy
  input wire logic       o_dq_oe,                // Watched
  input wire logic       o_wait,                 // Watched
  input wire logic       o_wait_oe,              // Watched
  input wire logic       o_wr_strobe,            // Watched
  input wire logic       o_abort                 // Watched
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  logic       clk_q;
  logic [4:0] wcnt_q;
  wire        wait_on = (o_wait == i_wait_polarity);
  // Burst clock rises seen while a read holds wait asserted; the design lags the
  // pins by its synchroniser, so only an upper bound is safe
  always_ff @(posedge i_core_clk)
  begin
    clk_q <= i_burst_clk;
    if (i_reset || !o_dq_oe || !wait_on)
      wcnt_q <= 5'h00;
    else if (i_burst_clk && !clk_q)
      wcnt_q <= wcnt_q + 5'h01;
  end
  sequence pin_reset_held;
    !i_reset_pin_n [*4];
  endsequence
  sequence select_from_idle(logic ok);
    i_chip_sel_n ##1 (!i_chip_sel_n && !i_out_en_n && i_wr_en_n && i_reset_pin_n && ok) [*6];
  endsequence
  sequence bus_write_end;
    (!i_chip_sel_n && !i_wr_en_n && i_out_en_n && i_reset_pin_n) ##1 i_wr_en_n [*2];
  endsequence
  a_reset_pads_off: assert property (pin_reset_held |-> !o_dq_oe && !o_wait_oe)
    else $error("pads driven while reset pin low");
  a_reset_abort: assert property (pin_reset_held ##0 i_op_busy |=> o_abort)
    else $error("busy operation not aborted");
  a_standby_quiet: assert property ((i_chip_sel_n && i_reset_pin_n) [*4]
    |-> !o_dq_oe && !o_wait_oe && !o_abort) else $error("standby not quiet");
  a_out_disable: assert property
    ((!i_chip_sel_n && i_out_en_n && i_reset_pin_n) [*4]
    |-> !o_dq_oe && o_wait_oe == i_shared_addr_data_variant && !(o_wait_oe && wait_on))
    else $error("output disable wrong");
  a_async_drive: assert property (select_from_idle(i_read_mode_select_bit)
    |-> o_dq_oe && o_wait_oe && !wait_on) else $error("async read not driven");
  a_burst_needs_addr: assert property
    (select_from_idle(!i_read_mode_select_bit && i_address_valid_low) |-> !o_dq_oe)
    else $error("burst began without address valid");
  a_wait_bound: assert property
    (wait_on && o_dq_oe |-> wcnt_q <= {1'b0, i_latency})
    else $error("wait held past latency");
  a_wr_answer: assert property (bus_write_end |-> ##[1:4] o_wr_strobe)
    else $error("no write strobe");
  a_wr_single: assert property (o_wr_strobe |=> !o_wr_strobe)
    else $error("write strobe too long");
endmodule // parallel_flash_bus_interface_asserts
`default_nettype wire

// File: test/flash_host_model.sv
`default_nettype none
module flash_host_model (
  input  wire logic        i_core_clk,          // Paces the host
  input  wire logic [15:0] i_dq_dev,            // Device data
  input  wire logic        i_dq_oe,             // Device drives data
  input  wire logic        i_wait,              // Wait pin
  input  wire logic        i_wait_pol,          // Wait polarity
  input  wire logic        i_mux,               // Multiplexed variant
  output var  logic        o_reset_pin_n,       // Reset pin
  output var  logic        o_chip_sel_n,        // Chip select
  output var  logic        o_out_en_n,          // Output enable
  output var  logic        o_wr_en_n,           // Write enable
  output var  logic        o_address_valid_low, // Address valid
  output var  logic        o_burst_clk,         // Still outside bursts
  output var  logic [23:0] o_addr,              // Address pins
  output var  logic [15:0] o_dq                 // Host side of data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_reset_pin_n = 1'b1;
    o_burst_clk = 1'b0;
    o_addr = 24'h000000;
    o_dq = 16'h0000;
    release_bus();
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic release_bus();
    o_chip_sel_n = 1'b1;
    o_out_en_n = 1'b1;
    o_wr_en_n = 1'b1;
    o_address_valid_low = 1'b1;
    o_dq = ~o_dq;  // A released line must not keep its last value
    cyc(4);
  endtask
  task automatic bus_write(input logic [23:0] a, input logic [15:0] d);
    o_addr = i_mux ? {a[23:16], 16'h0000} : a;
    o_dq = i_mux ? a[15:0] : d;
    o_chip_sel_n = 1'b0;
    o_address_valid_low = 1'b0;
    o_wr_en_n = 1'b0;
    cyc(4);
    o_address_valid_low = 1'b1;
    cyc(2);
    o_dq = d;
    cyc(2);
    o_wr_en_n = 1'b1;
    cyc(5);
    release_bus();
  endtask
  task automatic async_read(input logic [23:0] a);
    o_addr = a;
    o_address_valid_low = 1'b0;
    o_chip_sel_n = 1'b0;
    o_out_en_n = 1'b0;
    cyc(8);
  endtask
  task automatic burst(input logic [23:0] a, input int n, output logic [15:0] w[$],
                       output int stalls);
    w = {};
    stalls = 0;
    o_addr = a;
    o_chip_sel_n = 1'b0;
    o_out_en_n = 1'b0;
    cyc(8);
    o_address_valid_low = 1'b0;
    cyc(3);
    for (int k = 0; k < 80 && w.size() < n; k++)
    begin
      o_burst_clk = 1'b1;
      if (i_dq_oe && i_wait != i_wait_pol)
        w.push_back(i_dq_dev);
      else if (w.size() != 0)
        stalls++;
      cyc(4);
      o_address_valid_low = 1'b1;
      o_burst_clk = 1'b0;
      cyc(4);
    end
    release_bus();
  endtask
endmodule // flash_host_model
`default_nettype wire

// File: test/parallel_flash_bus_interface_test.sv
`default_nettype none
`define CHK(g, e) check_val(24'(g), 24'(e))
module parallel_flash_bus_interface_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_core_clk, i_reset, i_read_mode_select_bit, i_burst_wrap_bit;
  logic        i_wait_polarity, i_shared_addr_data_variant, i_fast_part;
  logic        i_array_mode, i_op_busy;
  logic [1:0]  i_burst_len;
  logic [3:0]  i_latency;
  wire         i_reset_pin_n, i_chip_sel_n, i_out_en_n, i_wr_en_n;
  wire         i_address_valid_low, i_burst_clk, o_dq_oe, o_wait, o_wait_oe;
  wire         o_wr_strobe, o_abort;
  wire  [23:0] i_addr, o_mem_addr, o_wr_addr;
  wire  [15:0] i_dq, host_dq, o_dq, o_wr_data, i_mem_rd_data;
  int          num_errors = 0;
  int          checks_done = 0;
  int          strobes = 0;
  function automatic logic [15:0] mem(input logic [23:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction
  function automatic logic [23:0] nxt(input logic [23:0] a, input logic [1:0] len,
                                      input logic wrapb);
    if (wrapb || len[1])
      return a + 24'h000001;
    if (len == 2'h0)
      return {a[23:3], a[2:0] + 3'h1};
    return {a[23:4], a[3:0] + 4'h1};
  endfunction
  flash_host_model host (
    .i_core_clk, .i_dq_dev(o_dq), .i_dq_oe(o_dq_oe), .i_wait(o_wait),
    .i_wait_pol(i_wait_polarity), .i_mux(i_shared_addr_data_variant),
    .o_reset_pin_n(i_reset_pin_n), .o_chip_sel_n(i_chip_sel_n), .o_out_en_n(i_out_en_n),
    .o_wr_en_n(i_wr_en_n), .o_address_valid_low(i_address_valid_low),
    .o_burst_clk(i_burst_clk), .o_addr(i_addr), .o_dq(host_dq)
  );
  parallel_flash_bus_interface uut (
    .i_core_clk, .i_reset, .i_reset_pin_n, .i_chip_sel_n, .i_out_en_n, .i_wr_en_n,
    .i_address_valid_low, .i_burst_clk, .i_addr, .i_dq, .o_dq, .o_dq_oe, .o_wait,
    .o_wait_oe, .i_read_mode_select_bit, .i_burst_wrap_bit, .i_burst_len, .i_latency,
    .i_wait_polarity, .i_shared_addr_data_variant, .i_fast_part, .i_array_mode,
    .i_op_busy, .i_mem_rd_data, .o_mem_addr, .o_wr_strobe, .o_wr_addr, .o_wr_data,
    .o_abort
  );
  assign i_dq = o_dq_oe ? o_dq : host_dq;
  assign i_mem_rd_data = mem(o_mem_addr);
  always @(posedge i_core_clk)
    if (o_wr_strobe === 1'b1)
      strobes++;
  task automatic check_val(input logic [23:0] g, input logic [23:0] e);
    checks_done++;
    if (g !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic t_async();
    host.async_read(24'h123450);
    `CHK(o_dq, mem(24'h123450));
    `CHK({o_dq_oe, o_wait_oe, o_wait}, {2'h3, ~i_wait_polarity});
    host.async_read(24'h12345F);
    `CHK(o_dq, mem(24'h12345F));
    host.o_out_en_n = 1'b1;
    host.cyc(6);
    `CHK({o_dq_oe, o_wait_oe}, 2'h0);
    host.release_bus();
    $display("test async read done");
  endtask
  task automatic t_reset_standby();
    host.async_read(24'h000ABC);
    i_op_busy = 1'b1;
    host.o_reset_pin_n = 1'b0;
    host.cyc(6);
    `CHK({o_dq_oe, o_wait_oe}, 2'h0);
    `CHK(o_abort, 1'b1);
    host.o_reset_pin_n = 1'b1;
    host.release_bus();
    host.cyc(10);  // Recovery before the next cycle
    host.o_out_en_n = 1'b0;
    host.cyc(6);
    `CHK({o_dq_oe, o_wait_oe, o_abort}, 3'h0);
    i_op_busy = 1'b0;
    host.release_bus();
    $display("test reset and standby done");
  endtask
  task automatic t_write(input logic mux, input logic [23:0] a, input logic [15:0] d);
    int s0;
    i_shared_addr_data_variant = mux;
    s0 = strobes;
    host.bus_write(a, d);
    `CHK(strobes - s0, 1);
    `CHK(o_wr_addr, a);
    `CHK(o_wr_data, d);
    i_shared_addr_data_variant = 1'b0;
    $display("test bus write done");
  endtask
  task automatic t_burst(input logic [23:0] a, input logic [1:0] len, input logic wrapb,
                         input logic arr, input logic [3:0] lat, input int n,
                         input logic fast, input logic stall);
    logic [15:0] w[$];
    logic [23:0] ea;
    int          st;
    ea = a;
    i_burst_len = len;
    i_burst_wrap_bit = wrapb;
    i_array_mode = arr;
    i_latency = lat;
    i_fast_part = fast;
    i_wait_polarity = fast;
    i_read_mode_select_bit = 1'b0;
    host.burst(a, n, w, st);
    `CHK(w.size(), n);
    foreach (w[k])
    begin
      `CHK(w[k], mem(arr ? ea : a));
      ea = nxt(ea, len, wrapb);
    end
    `CHK(st != 0, stall);
    i_read_mode_select_bit = 1'b1;
    $display("test burst read done");
  endtask
  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  initial
  begin
    {i_reset, i_read_mode_select_bit, i_burst_wrap_bit, i_wait_polarity} = 4'hF;
    {i_shared_addr_data_variant, i_fast_part, i_array_mode, i_op_busy} = 4'h2;
    {i_burst_len, i_latency} = 6'h03;
    repeat (6) @(negedge i_core_clk);
    i_reset = 1'b0;
    host.cyc(6);
    t_async();
    t_reset_standby();
    t_write(1'b0, 24'hABCDEF, 16'h1234);
    t_write(1'b1, 24'h5A6B7C, 16'hC3E1);
    t_burst(24'h000105, 2'h0, 1'b0, 1'b1, 4'h3, 8, 1'b0, 1'b0);
    t_burst(24'h00033C, 2'h1, 1'b0, 1'b1, 4'h5, 16, 1'b1, 1'b0);
    t_burst(24'h00010B, 2'h1, 1'b1, 1'b1, 4'h4, 16, 1'b1, 1'b0);
    t_burst(24'h0001FA, 2'h2, 1'b0, 1'b1, 4'h4, 12, 1'b0, 1'b1);
    t_burst(24'h0002F0, 2'h2, 1'b1, 1'b1, 4'h3, 20, 1'b1, 1'b0);
    t_burst(24'h000123, 2'h0, 1'b0, 1'b0, 4'h2, 8, 1'b0, 1'b0);
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge i_core_clk);
    num_errors++;
    print_verdict();
  end
endmodule // parallel_flash_bus_interface_test
bind parallel_flash_bus_interface parallel_flash_bus_interface_asserts chk (
  .i_core_clk, .i_reset, .i_reset_pin_n, .i_chip_sel_n, .i_out_en_n, .i_wr_en_n,
  .i_address_valid_low, .i_burst_clk, .i_read_mode_select_bit, .i_latency,
  .i_wait_polarity, .i_shared_addr_data_variant, .i_op_busy, .o_dq_oe, .o_wait,
  .o_wait_oe, .o_wr_strobe, .o_abort
);
`default_nettype wire
